// *** src/acs_sequencer.sv ***
`timescale 1ns/10ps
// How it works
// [RULE1] mode code 1,0,0 starts system offset calibration
// [RULE2] offset from analog input, gain from span
// [RULE3] offset calibration single step, then ready low
// [RULE4] unipolar endpoints, bipolar midscale to full scale
// [RULE5] background interleaves shorted and reference conversions
// [RULE6] mode code 1,0,1 enters background calibration
// [RULE7] background output rate divided by six
// [RULE8] background keeps updating coefficients without commands
// [RULE9] background holds until mode field changes
// [RULE10] host discards first background result
// [RULE11] background output settled by second update
// [RULE12] nine, four per step, six periods
// [RULE13] reset loads control register default
// [RULE14] host should calibrate after power-up
// [RULE15] reads from data, control, calibration words
// [RULE16] writes only control and calibration words
// [RULE17] serial clock made here or by host
// [RULE18] self 0,0,1; system 0,1,0 then 0,1,1
// [RULE19] calibrations end with ready line low
// [RULE20] host ignores ready briefly after command
// [RULE21] every calibration command resets the filter
// [RULE22] other codes keep coefficients, normal rate
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int W = ACS_W,
    parameter logic [15:0] SCLK_DIV = 16'(SCLK_HALF_CYC)
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic conv_valid,
    input wire logic [W-1:0] conv_result,
    input wire logic xfer_start,
    input wire acs_xfer_type xfer_req,
    input wire logic sclk_master,
    input wire logic sclk_in,
    output acs_src_type mux_sel_q,
    output logic filter_reset_q,
    output logic data_ready_n_q,
    output logic [W-1:0] out_data_q,
    output logic [W-1:0] xfer_rdata_q,
    output logic xfer_done_q,
    output logic xfer_busy_q,
    output logic sclk_out_q,
    output logic sclk_oe_n_q
);
    typedef enum logic [1:0] {ST_NORMAL, ST_CAL, ST_BG} acs_state_type;

    acs_state_type state_q, state_d;
    acs_src_type src_d;
    logic [2:0] cal_q, cal_d;
    logic [3:0] cnt_q, cnt_d;
    logic [3:0] cnt_inc;
    logic bg_full_q, bg_full_d;
    logic [W-1:0] ctrl_q, ctrl_d;
    acs_coef_type coef_q, coef_d;
    logic [W-1:0] out_d, rdata_d;
    logic rdy_n_d, frst_d, done_d, busy_d;
    acs_xfer_type req_q, req_d;
    logic [4:0] bit_q, bit_d;
    logic [15:0] div_q, div_d;
    logic sclk_d, oe_n_d, sclk_prev_q;
    logic bit_edge, xfer_end, new_word, diag;
    logic [2:0] wmode;
    logic [W-1:0] diff, span;

    assign diff = conv_result - coef_q.offset;
    assign cnt_inc = cnt_q + 4'h1;
    // bipolar calibrates midscale to +full scale, so only half the span is measured
    assign span = ctrl_q[CTRL_BIPOLAR_POS] ? {diff[W-2:0], 1'b0} : diff; // [RULE4]
    assign wmode = req_q.wdata[CTRL_MODE_POS +: 3];

    always_comb begin
        state_d = state_q;
        src_d = mux_sel_q;
        cal_d = cal_q;
        cnt_d = cnt_q;
        bg_full_d = bg_full_q;
        ctrl_d = ctrl_q;
        coef_d = coef_q;
        out_d = out_data_q;
        rdata_d = xfer_rdata_q;
        rdy_n_d = data_ready_n_q;
        frst_d = 1'b0;
        done_d = 1'b0;
        busy_d = xfer_busy_q;
        req_d = req_q;
        bit_d = bit_q;
        div_d = div_q;
        sclk_d = sclk_out_q;
        oe_n_d = ~sclk_master; // [RULE17]
        new_word = 1'b0;
        bit_edge = 1'b0;
        xfer_end = 1'b0;
        diag = 1'b0;

        // conversion sequencing
        unique case (state_q)
            ST_NORMAL: begin
                if (conv_valid) begin
                    new_word = 1'b1; // [RULE22]
                end
            end
            ST_CAL: begin
                if (conv_valid) begin
                    cnt_d = cnt_inc;
                    unique case (cal_q)
                        ACS_MODE_SYS_ZERO: begin
                            if (cnt_inc == 4'h1) begin
                                coef_d.offset = conv_result; // [RULE18]
                            end
                            diag = (cnt_inc == SYS_PERIODS); // [RULE12]
                        end
                        ACS_MODE_SYS_FULL: begin
                            if (cnt_inc == 4'h1) begin
                                coef_d.gain = span; // [RULE18]
                            end
                            diag = (cnt_inc == SYS_PERIODS); // [RULE12]
                        end
                        default: begin
                            // self and system offset: zero point, then reference
                            if (cnt_inc == 4'h1) begin
                                coef_d.offset = conv_result; // [RULE2]
                                src_d = ACS_SRC_REF;
                            end
                            if (cnt_inc == 4'h2) begin
                                coef_d.gain = span; // [RULE2]
                                src_d = ACS_SRC_ANALOG;
                            end
                            diag = (cnt_inc == SELF_PERIODS); // [RULE12]
                        end
                    endcase
                    if (diag) begin
                        state_d = ST_NORMAL; // [RULE3]
                        new_word = 1'b1; // [RULE19]
                    end
                end
            end
            ST_BG: begin
                // one calibration conversion in every six, zero and full scale alternating
                if (conv_valid) begin
                    cnt_d = cnt_inc;
                    if (cnt_inc == 4'h1) begin
                        src_d = ACS_SRC_ANALOG;
                        if (bg_full_q) begin
                            coef_d.gain = span; // [RULE8]
                        end else begin
                            coef_d.offset = conv_result; // [RULE8]
                        end
                    end
                    if (cnt_inc == BG_PERIODS) begin
                        new_word = 1'b1; // [RULE7]
                        cnt_d = 4'h0;
                        bg_full_d = ~bg_full_q;
                        src_d = bg_full_q ? ACS_SRC_SHORT : ACS_SRC_REF; // [RULE5]
                    end
                end
            end
        endcase

        if (new_word) begin
            out_d = diff; // [RULE11]
        end

        // host transfer: 24 serial clocks per word
        if (!xfer_busy_q) begin
            sclk_d = 1'b0;
            if (xfer_start && !(!xfer_req.write && xfer_req.addr == ACS_ADDR_DATA && data_ready_n_q)) begin
                busy_d = 1'b1;
                req_d = xfer_req;
                bit_d = 5'h0;
                div_d = 16'h0;
                unique case (xfer_req.addr)
                    ACS_ADDR_CTRL: rdata_d = ctrl_q; // [RULE15]
                    ACS_ADDR_DATA: rdata_d = out_data_q; // [RULE15]
                    ACS_ADDR_OFFS: rdata_d = coef_q.offset; // [RULE15]
                    ACS_ADDR_GAIN: rdata_d = coef_q.gain; // [RULE15]
                endcase
            end
        end else begin
            if (sclk_master) begin
                div_d = div_q + 16'h1;
                if (div_q == SCLK_DIV - 16'h1) begin
                    div_d = 16'h0;
                    sclk_d = ~sclk_out_q;
                    bit_edge = ~sclk_out_q; // [RULE17]
                end
            end else begin
                bit_edge = sclk_in && !sclk_prev_q; // [RULE17]
            end
            if (bit_edge) begin
                bit_d = bit_q + 5'h1;
                xfer_end = (bit_q == XFER_BITS - 5'h1);
            end
        end

        if (xfer_end) begin
            busy_d = 1'b0;
            done_d = 1'b1;
            if (req_q.write) begin
                unique case (req_q.addr)
                    ACS_ADDR_CTRL: begin
                        ctrl_d = req_q.wdata;
                        cnt_d = 4'h0;
                        bg_full_d = 1'b0;
                        src_d = ACS_SRC_ANALOG;
                        state_d = ST_NORMAL; // [RULE9]
                        if (wmode >= ACS_MODE_SELF && wmode <= ACS_MODE_BACKGND) begin
                            frst_d = 1'b1; // [RULE21]
                            rdy_n_d = 1'b1;
                            // a word landing with the command must not pull ready low
                            new_word = 1'b0; // [RULE19]
                            cal_d = wmode;
                            state_d = (wmode == ACS_MODE_BACKGND) ? ST_BG : ST_CAL; // [RULE1] [RULE6]
                            if (wmode == ACS_MODE_SELF || wmode == ACS_MODE_BACKGND) begin
                                src_d = ACS_SRC_SHORT; // [RULE18] [RULE5]
                            end
                        end
                    end
                    ACS_ADDR_OFFS: coef_d.offset = req_q.wdata; // [RULE16]
                    ACS_ADDR_GAIN: coef_d.gain = req_q.wdata; // [RULE16]
                    default: ; // output word is read only [RULE16]
                endcase
            end else if (req_q.addr == ACS_ADDR_DATA) begin
                rdy_n_d = 1'b1;
            end
        end

        // a word landing as a read finishes still pulls ready low
        if (new_word) begin
            rdy_n_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_NORMAL;
            mux_sel_q <= ACS_SRC_ANALOG;
            cal_q <= ACS_MODE_NONE;
            cnt_q <= 4'h0;
            bg_full_q <= 1'b0;
            ctrl_q <= CTRL_RESET; // [RULE13]
            coef_q <= {OFFS_RESET, GAIN_RESET};
            out_data_q <= '0;
            xfer_rdata_q <= '0;
            data_ready_n_q <= 1'b1;
            filter_reset_q <= 1'b0;
            xfer_done_q <= 1'b0;
            xfer_busy_q <= 1'b0;
            req_q <= '0;
            bit_q <= 5'h0;
            div_q <= 16'h0;
            sclk_out_q <= 1'b0;
            sclk_oe_n_q <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mux_sel_q <= src_d;
            cal_q <= cal_d;
            cnt_q <= cnt_d;
            bg_full_q <= bg_full_d;
            ctrl_q <= ctrl_d;
            coef_q <= coef_d;
            out_data_q <= out_d;
            xfer_rdata_q <= rdata_d;
            data_ready_n_q <= rdy_n_d;
            filter_reset_q <= frst_d;
            xfer_done_q <= done_d;
            xfer_busy_q <= busy_d;
            req_q <= req_d;
            bit_q <= bit_d;
            div_q <= div_d;
            sclk_out_q <= sclk_d;
            sclk_oe_n_q <= oe_n_d;
            sclk_prev_q <= sclk_in;
        end
    end
endmodule // acs_sequencer

// *** src/acs_pkg.sv ***
package acs_pkg;
    localparam int ACS_W = 24;
    localparam int CLK_MHZ = 200;

    // calibration mode codes in the three-bit mode field
    localparam logic [2:0] ACS_MODE_NONE = 3'h0;
    localparam logic [2:0] ACS_MODE_SELF = 3'h1;
    localparam logic [2:0] ACS_MODE_SYS_ZERO = 3'h2;
    localparam logic [2:0] ACS_MODE_SYS_FULL = 3'h3;
    localparam logic [2:0] ACS_MODE_SYS_OFFS = 3'h4;
    localparam logic [2:0] ACS_MODE_BACKGND = 3'h5;

    // control word layout
    localparam int CTRL_MODE_POS = 21;
    localparam int CTRL_BIPOLAR_POS = 20;
    localparam logic [ACS_W-1:0] CTRL_RESET = 24'h00_0000;
    localparam logic [ACS_W-1:0] OFFS_RESET = 24'h00_0000;
    localparam logic [ACS_W-1:0] GAIN_RESET = 24'h80_0000;

    // word addresses on the host port
    localparam logic [1:0] ACS_ADDR_CTRL = 2'h0;
    localparam logic [1:0] ACS_ADDR_DATA = 2'h1;
    localparam logic [1:0] ACS_ADDR_OFFS = 2'h2;
    localparam logic [1:0] ACS_ADDR_GAIN = 2'h3;

    // durations in output periods
    localparam logic [3:0] SELF_PERIODS = 4'h9;
    localparam logic [3:0] SYS_PERIODS = 4'h4;
    localparam logic [3:0] BG_PERIODS = 4'h6;

    // serial clock half period when this end makes the clock
    localparam int SCLK_HALF_NS = 50;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] XFER_BITS = 5'h18;

    typedef enum logic [1:0] {
        ACS_SRC_ANALOG,
        ACS_SRC_SHORT,
        ACS_SRC_REF
    } acs_src_type;

    typedef struct packed {
        logic [ACS_W-1:0] offset;
        logic [ACS_W-1:0] gain;
    } acs_coef_type;

    typedef struct packed {
        logic write;
        logic [1:0] addr;
        logic [ACS_W-1:0] wdata;
    } acs_xfer_type;
endpackage

// *** bench/acs_sequencer_checker.sv ***
`timescale 1ns/10ps
module acs_sequencer_checker
    import acs_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic conv_valid,
    input wire logic xfer_start,
    input wire acs_xfer_type xfer_req,
    input wire logic sclk_master,
    input wire logic filter_reset_q,
    input wire logic data_ready_n_q,
    input wire logic [ACS_W-1:0] out_data_q,
    input wire logic xfer_done_q,
    input wire logic xfer_busy_q,
    input wire logic sclk_out_q,
    input wire logic sclk_oe_n_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_acc;
        xfer_start && !xfer_busy_q && xfer_req.write;
    endsequence
    sequence s_cal;
        s_acc ##0 (xfer_req.addr == ACS_ADDR_CTRL && xfer_req.wdata[23:21] inside {[3'h1:3'h5]});
    endsequence
    property p_busy; s_acc |=> xfer_busy_q; endproperty
    a_busy: assert property (p_busy) else $error("busy not raised");
    property p_cal; s_cal |-> ##[1:1000] filter_reset_q; endproperty
    a_cal: assert property (p_cal) else $error("no filter reset");
    property p_rst_pulse; filter_reset_q |=> !filter_reset_q; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("filter reset too long");
    property p_rst_rdy; filter_reset_q |-> data_ready_n_q; endproperty
    a_rst_rdy: assert property (p_rst_rdy) else $error("ready low at command");
    property p_fell; $fell(data_ready_n_q) |-> $past(conv_valid); endproperty
    a_fell: assert property (p_fell) else $error("ready without conversion");
    property p_out; $changed(out_data_q) |-> $past(conv_valid); endproperty
    a_out: assert property (p_out) else $error("output without conversion");
    property p_done; xfer_done_q |-> !xfer_busy_q ##1 !xfer_done_q; endproperty
    a_done: assert property (p_done) else $error("bad done pulse");
    property p_oe; sclk_master |=> !sclk_oe_n_q; endproperty
    a_oe: assert property (p_oe) else $error("clock not driven");
    property p_idle; !xfer_busy_q [*2] |-> !sclk_out_q; endproperty
    a_idle: assert property (p_idle) else $error("clock runs idle");
endmodule // acs_sequencer_checker

bind acs_sequencer acs_sequencer_checker chk_u (.clk(clk), .srst(srst), .conv_valid(conv_valid),
    .xfer_start(xfer_start), .xfer_req(xfer_req), .sclk_master(sclk_master), .filter_reset_q(filter_reset_q),
    .data_ready_n_q(data_ready_n_q), .out_data_q(out_data_q), .xfer_done_q(xfer_done_q),
    .xfer_busy_q(xfer_busy_q), .sclk_out_q(sclk_out_q), .sclk_oe_n_q(sclk_oe_n_q));

// *** bench/acs_conv_model.sv ***
`timescale 1ns/10ps
module acs_conv_model
    import acs_pkg::*;
#(
    parameter int PERIOD = 150
) (
    input wire logic clk,
    input wire logic filter_reset,
    input wire acs_src_type mux_sel,
    input wire logic [ACS_W-1:0] analog_input,
    input wire logic [ACS_W-1:0] ref_level,
    output logic conv_valid,
    output logic [ACS_W-1:0] conv_result
);
    int cnt = 1;
    initial conv_valid = 1'b0;
    initial conv_result = 24'h00_0000;
    // result toggles between pulses: only the pulse cycle carries meaning
    always @(negedge clk) begin
        cnt <= (filter_reset || cnt == PERIOD) ? 1 : cnt + 1;
        conv_valid <= (cnt == PERIOD) && !filter_reset;
        conv_result <= (cnt != PERIOD) ? ~conv_result : (mux_sel == ACS_SRC_REF) ? ref_level :
            (mux_sel == ACS_SRC_SHORT) ? 24'h00_0000 : analog_input;
    end
endmodule // acs_conv_model

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import acs_pkg::*;
    localparam logic [23:0] REF_LVL = 24'h60_0000;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic cv, frst, rdy_n, done, busy, sco, sco_p, oe_n;
    logic mst = 1'b1;
    logic sclk_h = 1'b0;
    logic [23:0] cres, outd, rdata, rd, off, a1;
    logic [23:0] ana = 24'h00_0000;
    acs_xfer_type req = '0;
    acs_src_type msel;
    int failures = 0, cmp_count = 0, cycles = 0, n, edges;
    always #2.5 clk = ~clk;
    acs_sequencer #(.SCLK_DIV(16'h0002)) dut_u (.clk(clk), .srst(srst), .conv_valid(cv), .conv_result(cres),
        .xfer_start(start), .xfer_req(req), .sclk_master(mst), .sclk_in(sclk_h), .mux_sel_q(msel),
        .filter_reset_q(frst), .data_ready_n_q(rdy_n), .out_data_q(outd), .xfer_rdata_q(rdata),
        .xfer_done_q(done), .xfer_busy_q(busy), .sclk_out_q(sco), .sclk_oe_n_q(oe_n));
    acs_conv_model model_u (.clk(clk), .filter_reset(frst), .mux_sel(msel), .analog_input(ana),
        .ref_level(REF_LVL), .conv_valid(cv), .conv_result(cres));
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [1:0] a, input logic [23:0] d);
        @(negedge clk);
        start = 1'b1;
        req = {w, a, d};
        @(negedge clk);
        start = 1'b0;
        edges = 0;
        sco_p = 1'b0;
        for (int i = 0; i < 1000 && !done; i++) begin
            @(negedge clk);
            // host-made clock runs only inside the frame
            if (!mst && !done) sclk_h = ~sclk_h;
            if (sco && !sco_p) edges++;
            sco_p = sco;
        end
        rd = rdata;
        chk(24'(edges), mst ? 24'(XFER_BITS) : 24'h00_0000);
        chk({23'h00_0000, busy}, 24'h00_0000);
    endtask
    // counts conversions until ready drops
    task automatic count_convs(input int exp);
        n = 0;
        for (int i = 0; i < 3000 && rdy_n; i++) begin
            @(negedge clk);
            if (cv) n++;
        end
        chk(24'(n), 24'(exp));
    endtask
    task automatic cal(input logic [2:0] mode, input logic bip, input int exp);
        xfer(1'b1, ACS_ADDR_CTRL, {mode, bip, 20'h0_0000});
        count_convs(exp);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(15));
        ana = 24'($urandom) & 24'h1f_ffff;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk({23'h00_0000, rdy_n}, 24'h00_0001);
        count_convs(1);
        xfer(1'b0, ACS_ADDR_DATA, 24'h00_0000); chk(rd, ana);
        count_convs(1);
        xfer(1'b0, ACS_ADDR_CTRL, 24'h00_0000); chk(rd, CTRL_RESET);
        xfer(1'b0, ACS_ADDR_GAIN, 24'h00_0000); chk(rd, GAIN_RESET);
        off = 24'($urandom) & 24'h0f_ffff;
        xfer(1'b1, ACS_ADDR_OFFS, off);
        xfer(1'b1, ACS_ADDR_DATA, 24'($urandom));
        xfer(1'b0, ACS_ADDR_OFFS, 24'h00_0000); chk(rd, off);
        xfer(1'b0, ACS_ADDR_DATA, 24'h00_0000); chk(rd, ana - off);
        cal(ACS_MODE_SELF, 1'b0, 9);
        xfer(1'b0, ACS_ADDR_OFFS, 24'h00_0000); chk(rd, 24'h00_0000);
        xfer(1'b0, ACS_ADDR_GAIN, 24'h00_0000); chk(rd, REF_LVL);
        cal(ACS_MODE_SYS_OFFS, 1'b0, 9);
        xfer(1'b0, ACS_ADDR_OFFS, 24'h00_0000); chk(rd, ana);
        xfer(1'b0, ACS_ADDR_GAIN, 24'h00_0000); chk(rd, REF_LVL - ana);
        xfer(1'b0, ACS_ADDR_DATA, 24'h00_0000); chk(rd, 24'h00_0000);
        cal(ACS_MODE_SYS_OFFS, 1'b1, 9);
        xfer(1'b0, ACS_ADDR_GAIN, 24'h00_0000); chk(rd, 24'((REF_LVL - ana) << 1));
        a1 = ana;
        cal(ACS_MODE_SYS_ZERO, 1'b0, 4);
        xfer(1'b0, ACS_ADDR_OFFS, 24'h00_0000); chk(rd, a1);
        ana = a1 + (24'($urandom) & 24'h0f_ffff) + 24'h00_0001;
        cal(ACS_MODE_SYS_FULL, 1'b0, 4);
        xfer(1'b0, ACS_ADDR_GAIN, 24'h00_0000); chk(rd, ana - a1);
        xfer(1'b1, ACS_ADDR_OFFS, off | 24'h00_0100);
        cal(ACS_MODE_BACKGND, 1'b0, 6);
        // first word is not yet gain-corrected, read only to clear ready
        xfer(1'b0, ACS_ADDR_DATA, 24'h00_0000);
        count_convs(6);
        xfer(1'b0, ACS_ADDR_OFFS, 24'h00_0000); chk(rd, 24'h00_0000);
        xfer(1'b0, ACS_ADDR_GAIN, 24'h00_0000); chk(rd, REF_LVL);
        xfer(1'b0, ACS_ADDR_DATA, 24'h00_0000); chk(rd, ana);
        // host clocks the rest; codes 6 and 7 leave background for normal conversions
        mst = 1'b0;
        off = {3'h6 | 3'($urandom & 1), 21'($urandom)};
        xfer(1'b1, ACS_ADDR_CTRL, off);
        chk({23'h00_0000, oe_n}, 24'h00_0001);
        xfer(1'b0, ACS_ADDR_CTRL, 24'h00_0000); chk(rd, off);
        count_convs(1);
        xfer(1'b0, ACS_ADDR_GAIN, 24'h00_0000); chk(rd, REF_LVL);
        complete_run();
    end
endmodule // tb_top
